// ===== design/asmt_pkg.sv
/*
  constants, field positions and types shared by the static memory
  access sequencer and its helpers.
  assumes a single 16-bit memory bank clocked from the system bus clock.
*/
package asmt_pkg;
  // bank control field positions
  localparam int CTL_ENABLE     = 31;
  localparam int CTL_BURST_WR   = 19;
  localparam int CTL_PAGE_HI    = 18;
  localparam int CTL_PAGE_LO    = 16;
  localparam int CTL_ASYNC_WAIT = 15;
  localparam int CTL_EXT_MODE   = 14;
  localparam int CTL_SYNC_WAIT  = 13;
  localparam int CTL_WAIT_POL   = 9;
  localparam int CTL_FLASH_EN   = 6;
  localparam int CTL_MEMORY_TYPE_HI    = 3;
  localparam int CTL_MEMORY_TYPE_LO    = 2;
  localparam int CTL_BANK_EN    = 0;
  localparam logic [1:0] MEMORY_TYPE_NOR = 2'h2;

  // read and write timing field positions
  localparam int TR_HLD_HI  = 31;
  localparam int TR_HLD_LO  = 30;
  localparam int TR_ACC_HI  = 29;
  localparam int TR_ACC_LO  = 28;
  localparam int TR_TURN_HI = 19;
  localparam int TR_TURN_LO = 16;
  localparam int TR_DSET_HI = 15;
  localparam int TR_DSET_LO = 8;
  localparam int TR_AHLD_HI = 7;
  localparam int TR_AHLD_LO = 4;
  localparam int TR_ASET_HI = 3;
  localparam int TR_ASET_LO = 0;

  // access mode field encodings
  localparam logic [1:0] ACC_A = 2'h0;
  localparam logic [1:0] ACC_B = 2'h1;
  localparam logic [1:0] ACC_C = 2'h2;
  localparam logic [1:0] ACC_D = 2'h3;

  // widths and sizes
  localparam int ADDR_W     = 26;
  localparam int DATA_W     = 16;
  localparam int BE_W       = 2;
  localparam int REQ_W      = 1 + BE_W + ADDR_W + DATA_W;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W      = 9;

  typedef enum logic [2:0] {ST_IDLE, ST_ASET, ST_AHLD, ST_DSET, ST_DHLD, ST_TURN} asmt_phase_e;
  typedef enum logic [2:0] {MD_1, MD_2, MD_A, MD_B, MD_C, MD_D} asmt_mode_e;
endpackage

// ===== design/asmt_fifo.sv
/*
  request fifo with parameter width and depth, valid/ready on both sides.
  assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
module asmt_fifo #(
  parameter int WIDTH = 45,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_in,
  input  wire logic             nrst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  // handshakes and pointer arithmetic
  always_comb begin
    push        = in_valid_in && in_ready_out;
    pop         = out_valid_out && out_ready_in;
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count  = AW'(0) + count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // pointers, count and registered flags
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      count         <= '0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      wr_ptr        <= next_wr_ptr;
      rd_ptr        <= next_rd_ptr;
      count         <= next_count;
      in_ready_out  <= next_count != FULL_CNT;
      out_valid_out <= next_count != '0;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  assign out_data_out = mem[rd_ptr];
endmodule
`default_nettype wire

// ===== design/asmt_phase_cnt.sv
/*
  down counter timing one access phase; load takes length minus one.
  assumes the sequencer loads it on every phase entry.
*/
`timescale 1ns/1ns
`default_nettype none
module asmt_phase_cnt #(
  parameter int W = 9
) (
  input  wire logic         clk_sys_in,
  input  wire logic         nrst_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] value_in,
  input  wire logic         en_in,
  output logic              zero_out
);
  logic [W-1:0] count, next_count;

  // load wins, otherwise count down while enabled
  always_comb begin
    next_count = count;
    if (load_in) begin
      next_count = value_in;
    end else if (en_in && count != '0) begin
      next_count = W'(count - 1'b1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign zero_out = count == '0;
endmodule
`default_nettype wire

// ===== design/asmt_seq.sv
/*
  asynchronous access sequencer for one static memory bank: modes 1, 2,
  A, B, C and D. requests pass a fifo, then address setup, address hold,
  data setup, data hold and turnaround phases drive the memory strobes.
  assumes configuration words are stable during an access and that all
  inputs, the memory wait among them, are synchronous to clk_sys_in.
*/
`timescale 1ns/1ns
`default_nettype none
module asmt_seq #(
  parameter int FIFO_DEPTH = asmt_pkg::FIFO_DEPTH
) (
  input  wire logic                        clk_sys_in,
  input  wire logic                        nrst_in,
  input  wire logic [31:0]                 bank_control_in,
  input  wire logic [31:0]                 bank_read_timing_in,
  input  wire logic [31:0]                 bank_write_timing_in,
  input  wire logic                        req_valid_in,
  output logic                             req_ready_out,
  input  wire logic                        req_write_in,
  input  wire logic [asmt_pkg::ADDR_W-1:0] req_addr_in,
  input  wire logic [asmt_pkg::DATA_W-1:0] req_wdata_in,
  input  wire logic [asmt_pkg::BE_W-1:0]   req_be_in,
  output logic                             rd_valid_out,
  output logic      [asmt_pkg::DATA_W-1:0] rd_data_out,
  output logic                             busy_out,
  input  wire logic                        mem_wait_in,
  input  wire logic [asmt_pkg::DATA_W-1:0] mem_data_in,
  output logic      [asmt_pkg::DATA_W-1:0] mem_data_out,
  output logic                             mem_data_oe_n_out,
  output logic      [asmt_pkg::ADDR_W-1:0] mem_addr_out,
  output logic                             chip_select_n_out,
  output logic                             output_enable_n_out,
  output logic                             write_enable_n_out,
  output logic      [asmt_pkg::BE_W-1:0]   byte_lane_n_out,
  output logic                             address_valid_n_out
);
  localparam int W = asmt_pkg::CNT_W;

  // phase length of one phase for a given timing word
  function automatic logic [W-1:0] phase_len(asmt_pkg::asmt_phase_e p, logic [31:0] tr,
                                              logic we, asmt_pkg::asmt_mode_e m);
    logic [W-1:0] len;
    len = '0;
    case (p)
      asmt_pkg::ST_ASET: len = W'(tr[asmt_pkg::TR_ASET_HI:asmt_pkg::TR_ASET_LO]);
      // address hold only in mode d
      asmt_pkg::ST_AHLD: len = (m == asmt_pkg::MD_D) ?
                               W'(tr[asmt_pkg::TR_AHLD_HI:asmt_pkg::TR_AHLD_LO]) : '0;
      // data setup, zero read as one
      asmt_pkg::ST_DSET: begin
        len = W'(tr[asmt_pkg::TR_DSET_HI:asmt_pkg::TR_DSET_LO]);
        if (len == '0) begin
          len = W'(1);
        end
      end
      asmt_pkg::ST_DHLD: len = W'(tr[asmt_pkg::TR_HLD_HI:asmt_pkg::TR_HLD_LO]) + W'(we);
      asmt_pkg::ST_TURN: len = W'(tr[asmt_pkg::TR_TURN_HI:asmt_pkg::TR_TURN_LO]);
      default: len = '0;
    endcase
    return len;
  endfunction

  // next phase in order, skipping empty ones
  function automatic asmt_pkg::asmt_phase_e advance(asmt_pkg::asmt_phase_e p,
                                                     logic [31:0] tr, logic we,
                                                     asmt_pkg::asmt_mode_e m);
    asmt_pkg::asmt_phase_e q;
    q = p;
    for (int i = 0; i < 5; i++) begin
      case (q)
        asmt_pkg::ST_IDLE: q = asmt_pkg::ST_ASET;
        asmt_pkg::ST_ASET: q = asmt_pkg::ST_AHLD;
        asmt_pkg::ST_AHLD: q = asmt_pkg::ST_DSET;
        asmt_pkg::ST_DSET: q = asmt_pkg::ST_DHLD;
        asmt_pkg::ST_DHLD: q = asmt_pkg::ST_TURN;
        default:           q = asmt_pkg::ST_IDLE;
      endcase
      if (q == asmt_pkg::ST_IDLE || phase_len(q, tr, we, m) != '0) begin
        break;
      end
    end
    return q;
  endfunction

  // waveform variant from control and timing words
  function automatic asmt_pkg::asmt_mode_e resolve_mode(logic [31:0] ctl, logic [31:0] tr);
    asmt_pkg::asmt_mode_e m;
    m = asmt_pkg::MD_1;
    if (!ctl[asmt_pkg::CTL_EXT_MODE]) begin
      m = (ctl[asmt_pkg::CTL_MEMORY_TYPE_HI:asmt_pkg::CTL_MEMORY_TYPE_LO] == asmt_pkg::MEMORY_TYPE_NOR) ?
          asmt_pkg::MD_2 : asmt_pkg::MD_1;
    end else begin
      case (tr[asmt_pkg::TR_ACC_HI:asmt_pkg::TR_ACC_LO])
        asmt_pkg::ACC_A: m = asmt_pkg::MD_A;
        asmt_pkg::ACC_B: m = asmt_pkg::MD_B;
        asmt_pkg::ACC_C: m = asmt_pkg::MD_C;
        default:         m = asmt_pkg::MD_D;
      endcase
    end
    return m;
  endfunction

  asmt_pkg::asmt_phase_e state, next_state;
  asmt_pkg::asmt_mode_e  cur_mode, next_mode;
  logic [31:0]                 cur_tr, next_tr, sel_tr;
  logic                        cur_we, next_we;
  logic [asmt_pkg::ADDR_W-1:0] cur_addr, next_addr;
  logic [asmt_pkg::DATA_W-1:0] cur_wdata, next_wdata, next_rd_data;
  logic [asmt_pkg::BE_W-1:0]   cur_be, next_be, next_lanes;
  logic                        next_rd_valid, next_active, toggle_oe, next_oe_n, next_adv_n;
  logic [asmt_pkg::REQ_W-1:0]  fifo_data;
  logic                        fifo_valid, pop, cnt_load, cnt_zero, waiting, phase_end;
  logic [W-1:0]                cnt_val, cnt_len;
  logic [W-1:0]                ph_cycles;

  // request fifo, back-pressure reaches the requester
  asmt_fifo #(.WIDTH(asmt_pkg::REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in   (clk_sys_in),
    .nrst_in      (nrst_in),
    .in_valid_in  (req_valid_in),
    .in_ready_out (req_ready_out),
    .in_data_in   ({req_write_in, req_be_in, req_addr_in, req_wdata_in}),
    .out_valid_out(fifo_valid),
    .out_ready_in (pop),
    .out_data_out (fifo_data)
  );

  // phase timer, frozen in data setup while the memory holds wait
  asmt_phase_cnt #(.W(W)) u_cnt (
    .clk_sys_in(clk_sys_in),
    .nrst_in   (nrst_in),
    .load_in   (cnt_load),
    .value_in  (cnt_val),
    .en_in     (!waiting),
    .zero_out  (cnt_zero)
  );

  // wait polarity counts only with wait support
  assign waiting = state == asmt_pkg::ST_DSET && bank_control_in[asmt_pkg::CTL_ASYNC_WAIT] &&
                   (mem_wait_in == bank_control_in[asmt_pkg::CTL_WAIT_POL]);
  assign phase_end = cnt_zero && !waiting;

  // write timing only in extended mode
  assign sel_tr = (bank_control_in[asmt_pkg::CTL_EXT_MODE] && fifo_data[asmt_pkg::REQ_W-1]) ?
                  bank_write_timing_in : bank_read_timing_in;

  // sequencer next state; burst, page and sync wait bits never read
  always_comb begin
    next_state    = state;
    next_mode     = cur_mode;
    next_tr       = cur_tr;
    next_we       = cur_we;
    next_addr     = cur_addr;
    next_wdata    = cur_wdata;
    next_be       = cur_be;
    next_rd_valid = 1'b0;
    next_rd_data  = rd_data_out;
    pop           = 1'b0;
    cnt_load      = 1'b0;
    cnt_len       = '0;
    case (state)
      asmt_pkg::ST_IDLE: begin
        // one access at a time, bank must be enabled
        if (fifo_valid && bank_control_in[asmt_pkg::CTL_ENABLE] &&
            bank_control_in[asmt_pkg::CTL_BANK_EN]) begin
          pop        = 1'b1;
          next_mode  = resolve_mode(bank_control_in, sel_tr);
          next_tr    = sel_tr;
          {next_we, next_be, next_addr, next_wdata} = fifo_data;
          next_state = advance(asmt_pkg::ST_IDLE, next_tr, next_we, next_mode);
          cnt_load   = 1'b1;
          cnt_len    = phase_len(next_state, next_tr, next_we, next_mode);
        end
      end
      asmt_pkg::ST_ASET, asmt_pkg::ST_AHLD, asmt_pkg::ST_DSET,
      asmt_pkg::ST_DHLD, asmt_pkg::ST_TURN: begin
        if (phase_end) begin
          // sample read data while output enable is still low
          if (state == asmt_pkg::ST_DSET && !cur_we) begin
            next_rd_valid = 1'b1;
            next_rd_data  = mem_data_in;
          end
          next_state = advance(state, cur_tr, cur_we, cur_mode);
          cnt_load   = next_state != asmt_pkg::ST_IDLE;
          cnt_len    = phase_len(next_state, cur_tr, cur_we, cur_mode);
        end
      end
      default: next_state = asmt_pkg::ST_IDLE;
    endcase
    cnt_val = W'(cnt_len - 1'b1);
  end

  // memory strobe values for the coming cycle
  always_comb begin
    next_active = next_state inside {asmt_pkg::ST_ASET, asmt_pkg::ST_AHLD,
                                     asmt_pkg::ST_DSET, asmt_pkg::ST_DHLD};
    // output enable toggles in modes a, c, d
    toggle_oe   = next_mode inside {asmt_pkg::MD_A, asmt_pkg::MD_C, asmt_pkg::MD_D};
    next_oe_n   = !(!next_we && (next_state == asmt_pkg::ST_DSET ||
                   (!toggle_oe && next_active && next_state != asmt_pkg::ST_DHLD)));
    // reads hold both byte lanes low
    next_lanes  = !next_active ? '1 : (next_we ? ~next_be : '0);
    // address valid pulses in setup for nor modes and mode d
    next_adv_n  = !(next_state == asmt_pkg::ST_ASET &&
                    !(next_mode inside {asmt_pkg::MD_1, asmt_pkg::MD_A}));
  end

  // every memory output comes from a rising-edge flop
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state               <= asmt_pkg::ST_IDLE;
      cur_mode            <= asmt_pkg::MD_1;
      cur_tr              <= '0;
      cur_we              <= 1'b0;
      cur_addr            <= '0;
      cur_wdata           <= '0;
      cur_be              <= '0;
      ph_cycles           <= '0;
      rd_valid_out        <= 1'b0;
      rd_data_out         <= '0;
      busy_out            <= 1'b0;
      mem_data_out        <= '0;
      mem_data_oe_n_out   <= 1'b1;
      mem_addr_out        <= '0;
      chip_select_n_out   <= 1'b1;
      output_enable_n_out <= 1'b1;
      write_enable_n_out  <= 1'b1;
      byte_lane_n_out     <= '1;
      address_valid_n_out <= 1'b1;
    end else begin
      state               <= next_state;
      cur_mode            <= next_mode;
      cur_tr              <= next_tr;
      cur_we              <= next_we;
      cur_addr            <= next_addr;
      cur_wdata           <= next_wdata;
      cur_be              <= next_be;
      ph_cycles           <= (next_state != state) ? '0 : W'(ph_cycles + 1'b1);
      rd_valid_out        <= next_rd_valid;
      rd_data_out         <= next_rd_data;
      busy_out            <= next_state != asmt_pkg::ST_IDLE;
      mem_data_out        <= next_wdata;
      mem_data_oe_n_out   <= !(next_active && next_we);
      mem_addr_out        <= next_addr;
      // chip select low only inside an access
      chip_select_n_out   <= !next_active;
      output_enable_n_out <= next_oe_n;
      // write enable low only in data setup
      write_enable_n_out  <= !(next_we && next_state == asmt_pkg::ST_DSET);
      byte_lane_n_out     <= next_lanes;
      address_valid_n_out <= next_adv_n;
    end
  end

  // checks on phase lengths and strobes
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  logic [W-1:0] aset_f, ahld_f, dset_f, turn_f, hld_f;
  assign aset_f = W'(cur_tr[asmt_pkg::TR_ASET_HI:asmt_pkg::TR_ASET_LO]);
  assign ahld_f = W'(cur_tr[asmt_pkg::TR_AHLD_HI:asmt_pkg::TR_AHLD_LO]);
  assign dset_f = W'(cur_tr[asmt_pkg::TR_DSET_HI:asmt_pkg::TR_DSET_LO]);
  assign turn_f = W'(cur_tr[asmt_pkg::TR_TURN_HI:asmt_pkg::TR_TURN_LO]);
  assign hld_f  = W'(cur_tr[asmt_pkg::TR_HLD_HI:asmt_pkg::TR_HLD_LO]);

  sequence read_dset_end;
    state == asmt_pkg::ST_DSET && !cur_we ##1 state != asmt_pkg::ST_DSET;
  endsequence

  aset_len_a: assert property (
    state == asmt_pkg::ST_ASET && next_state != state |-> W'(ph_cycles + 1'b1) == aset_f)
    else $error("address setup length wrong");
  ahld_len_a: assert property (
    state == asmt_pkg::ST_AHLD && next_state != state |->
      cur_mode == asmt_pkg::MD_D && W'(ph_cycles + 1'b1) == ahld_f)
    else $error("address hold length wrong");
  dset_len_a: assert property (
    state == asmt_pkg::ST_DSET && next_state != state &&
      !bank_control_in[asmt_pkg::CTL_ASYNC_WAIT] && dset_f != '0 |->
      W'(ph_cycles + 1'b1) == dset_f)
    else $error("data setup length wrong");
  hold_len_a: assert property (
    state == asmt_pkg::ST_DHLD && next_state != state |->
      W'(ph_cycles + 1'b1) == W'(hld_f + W'(cur_we)))
    else $error("data hold length wrong");
  turn_len_a: assert property (
    state == asmt_pkg::ST_TURN && next_state != state |->
      W'(ph_cycles + 1'b1) == turn_f && chip_select_n_out)
    else $error("turnaround length wrong");
  phase_order_a: assert property (
    state != $past(state) |-> state == asmt_pkg::ST_IDLE || state > $past(state))
    else $error("phase order broken");
  read_sample_a: assert property (
    read_dset_end |-> rd_valid_out && $past(output_enable_n_out) == 1'b0)
    else $error("read data not sampled before output enable rise");
  read_lanes_a: assert property (
    !chip_select_n_out && !cur_we && cur_mode == asmt_pkg::MD_A |-> byte_lane_n_out == '0)
    else $error("mode a read lanes not low");
  we_pulse_a: assert property (
    !write_enable_n_out |-> state == asmt_pkg::ST_DSET && cur_we && !chip_select_n_out)
    else $error("write enable outside data setup");
  cs_single_a: assert property (
    !chip_select_n_out |-> busy_out && state != asmt_pkg::ST_TURN && !pop)
    else $error("chip select outside one access");
endmodule
`default_nettype wire

// ===== dv/asmt_mem_model.sv
/*
  behavioural static memory facing the access sequencer.
  assumes registered strobes; wait is high while it stalls.
*/
`timescale 1ns/1ns
`default_nettype none
module asmt_mem_model (
  input  wire logic        clk_sys_in,
  input  wire logic [25:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        cs_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic [1:0]  bl_n_in,
  input  wire logic [3:0]  stall_in,
  output logic             wait_out,
  output logic      [15:0] rdata_out
);
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0000;
  logic [3:0]  stall_cnt = 4'h0;
  logic        cs_d = 1'b1;
  // drive when read-enabled, else a word that changes every cycle
  assign rdata_out = (!cs_n_in && !oe_n_in) ? mem[addr_in[7:0]] : ~last;
  assign wait_out  = !cs_n_in && (stall_cnt != 4'h0);
  initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
  // lane writes and a stall countdown from each select
  always @(posedge clk_sys_in) begin
    cs_d <= cs_n_in;
    last <= rdata_out;
    if (cs_d && !cs_n_in) stall_cnt <= stall_in;
    else if (stall_cnt != 4'h0) stall_cnt <= stall_cnt - 4'h1;
    if (!cs_n_in && !we_n_in && !bl_n_in[0]) mem[addr_in[7:0]][7:0] <= wdata_in[7:0];
    if (!cs_n_in && !we_n_in && !bl_n_in[1]) mem[addr_in[7:0]][15:8] <= wdata_in[15:8];
  end
endmodule
`default_nettype wire

// ===== dv/asmt_seq_tb.sv
/*
  self-checking bench: strobe lengths per mode, read back, turnaround,
  wait, enable gating and fifo fill.
  assumes the memory model of asmt_mem_model.sv.
*/
`timescale 1ns/1ns
`default_nettype none
module asmt_seq_tb;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in    = 1'b0;
  logic [31:0] ctl = 32'h0, rt = 32'h0, wt = 32'h0;
  logic        req_valid = 1'b0, req_write = 1'b0;
  logic [25:0] req_addr  = 26'h0, mem_addr;
  logic [15:0] req_wdata = 16'h0, rd_data, mem_rdata, mem_wdata, rd_last;
  logic [1:0]  req_be = 2'h0, bl_n;
  logic [3:0]  stall  = 4'h0;
  logic        req_ready, rd_valid, busy, wait_s, doe_n, cs_n, oe_n, we_n, adv_n;
  int          fails = 0, n_tests = 0, n_acc = 0, gh = 0, n0;
  int          cl = 0, ol = 0, wl = 0, al = 0, dl = 0, e_cs, e_oe, e_we, e_adv, e_tn;
  int          cs_a[64], oe_a[64], we_a[64], adv_a[64], gap_a[64], doe_a[64];
  logic [1:0]  bl_a[64];

  always #4 clk_sys_in = ~clk_sys_in;

  asmt_seq u_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .bank_control_in(ctl),
    .bank_read_timing_in(rt), .bank_write_timing_in(wt), .req_valid_in(req_valid),
    .req_ready_out(req_ready), .req_write_in(req_write), .req_addr_in(req_addr),
    .req_wdata_in(req_wdata), .req_be_in(req_be), .rd_valid_out(rd_valid),
    .rd_data_out(rd_data), .busy_out(busy), .mem_wait_in(wait_s), .mem_data_in(mem_rdata),
    .mem_data_out(mem_wdata), .mem_data_oe_n_out(doe_n), .mem_addr_out(mem_addr),
    .chip_select_n_out(cs_n), .output_enable_n_out(oe_n), .write_enable_n_out(we_n),
    .byte_lane_n_out(bl_n), .address_valid_n_out(adv_n));

  asmt_mem_model u_mem (.clk_sys_in(clk_sys_in), .addr_in(mem_addr), .wdata_in(mem_wdata),
    .cs_n_in(cs_n), .oe_n_in(oe_n), .we_n_in(we_n), .bl_n_in(bl_n), .stall_in(stall),
    .wait_out(wait_s), .rdata_out(mem_rdata));

  // per access: strobe low lengths, lanes and the select-high gap before it
  always @(posedge clk_sys_in) begin
    if (rd_valid === 1'b1) rd_last <= rd_data;
    if (cs_n === 1'b0) begin
      if (cl == 0) gap_a[n_acc] <= gh;
      cl <= cl + 1;
      ol <= ol + int'(!oe_n);
      wl <= wl + int'(!we_n);
      al <= al + int'(!adv_n);
      dl <= dl + int'(!doe_n);
      bl_a[n_acc] <= bl_n;
      gh <= 0;
    end else begin
      if (cl != 0) begin
        cs_a[n_acc] <= cl;
        oe_a[n_acc] <= ol;
        we_a[n_acc] <= wl;
        adv_a[n_acc] <= al;
        doe_a[n_acc] <= dl;
        n_acc <= n_acc + 1;
      end
      {cl, ol, wl, al, dl} <= '0;
      gh <= gh + 1;
    end
  end

  function automatic logic [31:0] tw(input int h, m, tn, ds, ah, st);
    return {h[1:0], m[1:0], 8'h00, tn[3:0], ds[7:0], ah[3:0], st[3:0]};
  endfunction

  // expected low lengths; md 0..5 stands for modes 1, 2, A, B, C, D
  task automatic expect_len(input logic [31:0] c, r, w, input logic wr);
    logic [31:0] t;
    int md, ds;
    t = (wr && c[14]) ? w : r;
    md = !c[14] ? int'(c[3:2] == 2'h2) : 2 + int'(t[29:28]);
    ds = (t[15:8] == 8'h00) ? 1 : int'(t[15:8]);
    e_cs = int'(t[3:0]) + (md == 5 ? int'(t[7:4]) : 0) + ds + int'(t[31:30]) + int'(wr);
    e_oe = wr ? 0 : ((md == 0 || md == 1 || md == 3) ? int'(t[3:0]) : 0) + ds;
    e_we = wr ? ds : 0;
    e_adv = (md == 0 || md == 2) ? 0 : int'(t[3:0]);
    e_tn = int'(t[19:16]);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one request, held until the edge that sees ready high
  task automatic push(input logic wr, input logic [25:0] a, input logic [15:0] d,
                      input logic [1:0] be);
    int k = 0;
    @(negedge clk_sys_in);
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = a;
    req_wdata = d;
    req_be    = be;
    while (req_ready !== 1'b1 && k < 500) begin
      @(negedge clk_sys_in);
      k++;
    end
    if (k >= 500) fails++;
    if (k >= 500) test_done();
    @(negedge clk_sys_in);
    req_valid = 1'b0;
  endtask

  // bounded wait for n finished accesses and an idle sequencer
  task automatic settle(input int n);
    int k = 0;
    while (!(n_acc >= n && busy === 1'b0) && k < 3000) begin
      @(negedge clk_sys_in);
      k++;
    end
    if (k >= 3000) fails++;
    if (k >= 3000) test_done();
  endtask

  // write then read back one address in the given configuration
  task automatic run_mode(input logic [31:0] c, r, w, input logic [25:0] a,
                          input logic [15:0] d, input logic [1:0] be);
    @(negedge clk_sys_in);
    {ctl, rt, wt} = {c, r, w};
    n0 = n_acc;
    push(1'b1, a, d, be);
    push(1'b0, a, 16'h0000, 2'h0);
    settle(n0 + 2);
    expect_len(c, r, w, 1'b1);
    chk(cs_a[n0], e_cs);
    chk(we_a[n0], e_we);
    chk(gap_a[n0 + 1], e_tn + 1);
    // write data drives the bus for the whole select-low time
    chk(doe_a[n0], e_cs);
    expect_len(c, r, w, 1'b0);
    chk(cs_a[n0 + 1], e_cs);
    chk(oe_a[n0 + 1], e_oe);
    chk(adv_a[n0 + 1], e_adv);
    chk(bl_a[n0 + 1], 2'b00);
    // reads leave the data bus to the memory
    chk(doe_a[n0 + 1], 0);
    chk(rd_last, {be[1] ? d[15:8] : 8'h00, be[0] ? d[7:0] : 8'h00});
    $display("test mode config %h done", c);
  endtask

  initial begin
    repeat (10) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    @(negedge clk_sys_in);
    chk({cs_n, oe_n, we_n, adv_n, bl_n, req_ready, busy, doe_n}, 9'h1FD);
    $display("test reset done");
    // data setup counts below are all nonzero
    run_mode(32'h800B_2001, tw(1, 0, 2, 3, 0, 2), tw(3, 1, 9, 9, 9, 9), 1, 16'hA55A, 2'h3);
    run_mode(32'h8000_0049, tw(0, 0, 1, 1, 0, 0), tw(2, 2, 5, 7, 0, 5), 2, 16'h1234, 2'h3);
    run_mode(32'h8000_4001, tw(2, 0, 0, 2, 0, 1), tw(0, 0, 3, 4, 0, 3), 3, 16'hBEEF, 2'h1);
    run_mode(32'h8000_4049, tw(1, 1, 1, 2, 0, 2), tw(2, 1, 0, 3, 0, 1), 4, 16'h5AA5, 2'h3);
    run_mode(32'h8000_4049, tw(0, 2, 2, 3, 0, 0), tw(1, 2, 1, 2, 0, 2), 5, 16'h0F0F, 2'h2);
    run_mode(32'h8000_4041, tw(1, 3, 1, 2, 2, 1), tw(0, 3, 2, 1, 3, 2), 6, 16'hC33C, 2'h3);
    // stalling memory: ignored without wait support, stretches it with
    {ctl, rt, stall} = {32'h8000_0201, tw(0, 0, 0, 1, 0, 2), 4'h6};
    n0 = n_acc;
    push(1'b0, 26'h1, 16'h0000, 2'h0);
    settle(n0 + 1);
    expect_len(ctl, rt, rt, 1'b0);
    chk(cs_a[n0], e_cs);
    ctl = 32'h8000_8201;
    push(1'b0, 26'h1, 16'h0000, 2'h0);
    settle(n0 + 2);
    // wait stands from the second select cycle for six cycles: setup grows by five
    chk(cs_a[n0 + 1], e_cs + 5);
    $display("test wait done");
    // bank off: sixteen writes queue, then the fifo refuses
    ctl = 32'h8000_8200;
    n0 = n_acc;
    for (int i = 0; i < 16; i++) push(1'b1, 26'h40 + i, 16'h1100 + i, 2'h3);
    chk(req_ready, 1'b0);
    chk(n_acc, n0);
    ctl = 32'h8000_8201;
    settle(n0 + 16);
    push(1'b0, 26'h4F, 16'h0000, 2'h0);
    settle(n0 + 17);
    chk(rd_last, 16'h110F);
    $display("test fifo done");
    test_done();
  end
endmodule
`default_nettype wire
